// >>> verilog/dcf_regs.sv
// Comparator B and C match registers and trace FIFO read-out port, APB slave.
// Assumes processor bus, change-of-flow and system reset inputs come from logic on clk.
//
// What this block does
// - Ordinary reset clears comparator and FIFO registers
// - End-run reset leaves contents unspecified
// - End-trace reset with enable, no begin keeps
// - B upper bits select address 15..8 levels
// - Full mode ignores B upper pattern
// - B lower bits select address 7..0 levels
// - C upper bits select address 15..8 levels
// - C lower bits select address 7..0 levels
// - FIFO high read gives entry bits 15..8
// - Event-only modes: FIFO high reads zero
// - FIFO low read gives entry low byte
// - FIFO low read advances read pointer
// - Full mode: comparator B matches data
// - Event-only modes store B event data
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps

module dcf_regs
   import dcf_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Processor bus and trace sources
   input  wire dcf_bus_t    coreBus,
   input  wire dcf_cof_t    cofCapture,
   input  wire dcf_sysrst_t sysReset,
   // Comparator and FIFO state
   output logic             cmpBMatch,
   output logic             cmpCMatch,
   output logic [3:0]       fifoCount,
   output logic             fifoFull
);

   // Comparator pattern and trace control registers
   logic [7:0]  cmpBUpper_r;
   logic [7:0]  cmpBLower_r;
   logic [7:0]  cmpCUpper_r;
   logic [7:0]  cmpCLower_r;
   logic [7:0]  traceCtrl_r;

   // Trace FIFO storage and pointers
   logic [15:0]           fifoMem [FIFO_DEPTH];
   logic [FIFO_PTR_W-1:0] wrPtr_r;
   logic [FIFO_PTR_W-1:0] rdPtr_r;
   logic [FIFO_CNT_W-1:0] count_r;
   logic [FIFO_PTR_W-1:0] wrPtr_nxt;
   logic [FIFO_PTR_W-1:0] rdPtr_nxt;
   logic [FIFO_CNT_W-1:0] count_nxt;

   // APB answer registers and registered match and FIFO-full outputs
   logic [31:0] prdata_r;
   logic        pready_r;
   logic        pslverr_r;
   logic        cmpBMatch_r;
   logic        cmpCMatch_r;
   logic        fifoFull_r;

   // Mode decode
   wire logic fullMode    = traceCtrl_r[CTRL_FULL_MODE];
   wire logic eventOnly   = traceCtrl_r[CTRL_EVENT_ONLY];
   wire logic dbgEnable   = traceCtrl_r[CTRL_DBG_ENABLE];
   wire logic beginTrig   = traceCtrl_r[CTRL_BEGIN_TRIG];
   wire logic captureEn   = traceCtrl_r[CTRL_CAPTURE_EN];

   // System reset classification
   wire logic keepOnTrace = sysReset.endTrace & dbgEnable & ~beginTrig;
   // End-run contents are unspecified, so holding them is the cheapest choice
   wire logic keepOnReset = keepOnTrace | sysReset.endRun;
   wire logic clearRegs   = sysReset.req & ~keepOnReset;

   // APB decode
   wire logic        apbAccess = psel & penable & ~pready_r;
   wire logic        apbDone   = psel & penable & pready_r;
   wire logic [15:0] regIdx    = paddr[17:2];
   wire logic        addrHigh0 = (paddr[31:18] == 14'h0000) & (paddr[1:0] == 2'b00);
   wire logic        selBUpper = addrHigh0 & (regIdx == IDX_CMP_B_UPPER);
   wire logic        selBLower = addrHigh0 & (regIdx == IDX_CMP_B_LOWER);
   wire logic        selCUpper = addrHigh0 & (regIdx == IDX_CMP_C_UPPER);
   wire logic        selCLower = addrHigh0 & (regIdx == IDX_CMP_C_LOWER);
   wire logic        selFHigh  = addrHigh0 & (regIdx == IDX_FIFO_HIGH);
   wire logic        selFLow   = addrHigh0 & (regIdx == IDX_FIFO_LOW);
   wire logic        selCtrl   = addrHigh0 & (regIdx == IDX_TRACE_CTRL);
   wire logic        selStat   = addrHigh0 & (regIdx == IDX_TRACE_STAT);
   wire logic        selAny    = selBUpper | selBLower | selCUpper | selCLower |
                                 selFHigh | selFLow | selCtrl | selStat;
   wire logic        byteWr    = pwrite & pstrb[0];
   // FIFO high/low decode but take no write path
   wire logic        wrBUpper  = apbDone & byteWr & selBUpper;
   wire logic        wrBLower  = apbDone & byteWr & selBLower;
   wire logic        wrCUpper  = apbDone & byteWr & selCUpper;
   wire logic        wrCLower  = apbDone & byteWr & selCLower;
   wire logic        wrCtrl    = apbDone & byteWr & selCtrl;
   wire logic        rdFLow    = apbDone & ~pwrite & selFLow;

   // Comparator B pattern: data in full mode, address otherwise
   logic [15:0] cmpBPattern;
   logic [15:0] cmpBSubject;
   logic [15:0] cmpBCare;
   logic [15:0] cmpCPattern;
   logic [15:0] bitEqB;
   logic [15:0] bitEqC;

   assign cmpBPattern = {cmpBUpper_r, cmpBLower_r};
   assign cmpBSubject = fullMode ? {8'h00, coreBus.data} : coreBus.addr;
   assign cmpBCare    = fullMode ? 16'h00FF : 16'hFFFF;
   assign cmpCPattern = {cmpCUpper_r, cmpCLower_r};

   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++) begin : g_cmpBit
         assign bitEqB[gi] = ~cmpBCare[gi] | (cmpBSubject[gi] == cmpBPattern[gi]);
         assign bitEqC[gi] = (coreBus.addr[gi] == cmpCPattern[gi]);
      end
   endgenerate

   wire logic matchB = coreBus.valid & (&bitEqB);
   wire logic matchC = coreBus.valid & (&bitEqC);

   // FIFO capture source selection
   wire logic        pushEvent = captureEn & eventOnly & matchB;
   wire logic        pushCof   = captureEn & ~eventOnly & cofCapture.valid;
   wire logic [15:0] pushData  = eventOnly ? {8'h00, coreBus.data} : cofCapture.addr;
   wire logic        fifoEmpty = (count_r == '0);
   wire logic        fifoIsFull = (count_r == FIFO_CNT_FULL);
   // A full FIFO drops new captures; the oldest entries are kept for software
   wire logic        doPush    = (pushEvent | pushCof) & ~fifoIsFull;
   wire logic        doPop     = rdFLow & ~fifoEmpty;

   // FIFO read-out view
   wire logic [15:0] headEntry = fifoEmpty ? ENTRY_RESET : fifoMem[rdPtr_r];
   wire logic [7:0]  headHigh  = eventOnly ? 8'h00 : headEntry[15:8];
   wire logic [7:0]  headLow   = headEntry[7:0];

   // Status view
   wire logic [7:0]  statusByte = {2'b00, fifoIsFull, fifoEmpty, count_r};

   // Read data mux
   logic [7:0] rdByte;
   always_comb begin
      rdByte = 8'h00;
      unique case (1'b1)
         selBUpper: rdByte = cmpBUpper_r;
         selBLower: rdByte = cmpBLower_r;
         selCUpper: rdByte = cmpCUpper_r;
         selCLower: rdByte = cmpCLower_r;
         selFHigh:  rdByte = headHigh;
         selFLow:   rdByte = headLow;
         selCtrl:   rdByte = traceCtrl_r;
         selStat:   rdByte = statusByte;
         default:   rdByte = 8'h00;
      endcase
   end

   // Pointer and count next values
   always_comb begin
      wrPtr_nxt = wrPtr_r;
      rdPtr_nxt = rdPtr_r;
      count_nxt = count_r;
      if (doPush) begin
         wrPtr_nxt = wrPtr_r + 1'b1;
      end
      if (doPop) begin
         rdPtr_nxt = rdPtr_r + 1'b1;
      end
      unique case ({doPush, doPop})
         2'b10:   count_nxt = count_r + 1'b1;
         2'b01:   count_nxt = count_r - 1'b1;
         default: count_nxt = count_r;
      endcase
   end

   // APB answer: one wait state, data registered with pready
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pready_r  <= 1'b0;
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else begin
         pready_r  <= apbAccess;
         pslverr_r <= apbAccess & ~selAny;
         if (apbAccess) begin
            prdata_r <= pwrite ? 32'h0000_0000 : {24'h00_0000, rdByte};
         end
      end
   end

   // Comparator B registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cmpBUpper_r <= CMP_RESET;
         cmpBLower_r <= CMP_RESET;
      end else if (clearRegs) begin
         cmpBUpper_r <= CMP_RESET;
         cmpBLower_r <= CMP_RESET;
      end else begin
         if (wrBUpper) begin
            cmpBUpper_r <= pwdata[7:0];
         end
         if (wrBLower) begin
            cmpBLower_r <= pwdata[7:0];
         end
      end
   end

   // Comparator C registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cmpCUpper_r <= CMP_RESET;
         cmpCLower_r <= CMP_RESET;
      end else if (clearRegs) begin
         cmpCUpper_r <= CMP_RESET;
         cmpCLower_r <= CMP_RESET;
      end else begin
         if (wrCUpper) begin
            cmpCUpper_r <= pwdata[7:0];
         end
         if (wrCLower) begin
            cmpCLower_r <= pwdata[7:0];
         end
      end
   end

   // Trace control; keeps its value through a holding reset so the mode survives
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         traceCtrl_r <= CTRL_RESET;
      end else if (clearRegs) begin
         traceCtrl_r <= CTRL_RESET;
      end else if (wrCtrl) begin
         traceCtrl_r <= pwdata[7:0] & CTRL_WR_MASK;
      end
   end

   // FIFO pointers and count
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
      end else if (clearRegs) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
      end else begin
         wrPtr_r <= wrPtr_nxt;
         rdPtr_r <= rdPtr_nxt;
         count_r <= count_nxt;
      end
   end

   // FIFO storage; APB writes never reach it
   generate
      for (gi = 0; gi < FIFO_DEPTH; gi++) begin : g_fifoEntry
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               fifoMem[gi] <= ENTRY_RESET;
            end else if (clearRegs) begin
               fifoMem[gi] <= ENTRY_RESET;
            end else if (doPush && (wrPtr_r == FIFO_PTR_W'(gi))) begin
               fifoMem[gi] <= pushData;
            end
         end
      end
   endgenerate

   // Registered comparator and FIFO status outputs
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cmpBMatch_r <= 1'b0;
         cmpCMatch_r <= 1'b0;
         fifoFull_r  <= 1'b0;
      end else begin
         cmpBMatch_r <= matchB;
         cmpCMatch_r <= matchC;
         fifoFull_r  <= (count_nxt == FIFO_CNT_FULL) & ~clearRegs;
      end
   end

   assign prdata    = prdata_r;
   assign pready    = pready_r;
   assign pslverr   = pslverr_r;
   assign cmpBMatch = cmpBMatch_r;
   assign cmpCMatch = cmpCMatch_r;
   assign fifoCount = count_r;
   assign fifoFull  = fifoFull_r;

endmodule : dcf_regs

// >>> verilog/dcf_pkg.sv
// Package for the debug comparator B/C and trace FIFO read-out block.
// Assumes a 32-bit APB master and a processor bus on the same 50 MHz clock.
package dcf_pkg;

   // Register indices as printed; byte address is four times the index
   localparam logic [15:0] IDX_CMP_B_UPPER = 16'h3012;
   localparam logic [15:0] IDX_CMP_B_LOWER = 16'h3013;
   localparam logic [15:0] IDX_CMP_C_UPPER = 16'h3014;
   localparam logic [15:0] IDX_CMP_C_LOWER = 16'h3015;
   localparam logic [15:0] IDX_FIFO_HIGH   = 16'h3016;
   localparam logic [15:0] IDX_FIFO_LOW    = 16'h3017;
   localparam logic [15:0] IDX_TRACE_CTRL  = 16'h3030;
   localparam logic [15:0] IDX_TRACE_STAT  = 16'h3031;

   // Reset values
   localparam logic [7:0]  CMP_RESET       = 8'h00;
   localparam logic [7:0]  FIFO_RD_RESET   = 8'h00;
   localparam logic [7:0]  CTRL_RESET      = 8'h00;

   // Trace control register fields
   localparam int          CTRL_FULL_MODE  = 0;
   localparam int          CTRL_EVENT_ONLY = 1;
   localparam int          CTRL_DBG_ENABLE = 2;
   localparam int          CTRL_BEGIN_TRIG = 3;
   localparam int          CTRL_CAPTURE_EN = 4;
   localparam logic [7:0]  CTRL_WR_MASK    = 8'h1F;

   // Trace status register fields
   localparam int          STAT_COUNT_LSB  = 0;
   localparam int          STAT_EMPTY      = 4;
   localparam int          STAT_FULL       = 5;

   // Trace FIFO geometry
   localparam int          FIFO_DEPTH      = 8;
   localparam int          FIFO_PTR_W      = 3;
   localparam int          FIFO_CNT_W      = 4;
   localparam logic [3:0]  FIFO_CNT_FULL   = 4'h8;
   localparam logic [15:0] ENTRY_RESET     = 16'h0000;

   // Cycles from access phase start to pready
   localparam int          APB_WAIT_CYCLES = 1;

   // One processor bus cycle as seen by the comparators
   typedef struct packed {
      logic        valid;
      logic [15:0] addr;
      logic [7:0]  data;
   } dcf_bus_t;

   // One change-of-flow capture offered by the trace logic
   typedef struct packed {
      logic        valid;
      logic [15:0] addr;
   } dcf_cof_t;

   // How the system reset that is under way was caused
   typedef struct packed {
      logic req;
      logic endRun;
      logic endTrace;
   } dcf_sysrst_t;

endpackage : dcf_pkg

// >>> tb/dcf_core_model.sv
// Processor stand-in: bus cycles, flow captures, system resets.
// Assumes its tasks are called from the bench between clock edges.
`timescale 1ns/100ps
module dcf_core_model
   import dcf_pkg::*;
(
   // Clock
   input wire logic clk,
   // Processor side
   output dcf_bus_t coreBus,
   output dcf_cof_t cofCapture,
   output dcf_sysrst_t sysReset
);
   initial begin
      coreBus = '0;
      cofCapture = '0;
      sysReset = '0;
   end
   // Idle lines show inverted values so a stale copy cannot match
   task automatic busCycle(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk) coreBus <= '{1'b1, a, d};
      @(posedge clk) coreBus <= '{1'b0, ~a, ~d};
   endtask : busCycle
   task automatic cof(input logic [15:0] a);
      @(posedge clk) cofCapture <= '{1'b1, a};
      @(posedge clk) cofCapture <= '{1'b0, ~a};
   endtask : cof
   task automatic sysRst(input logic run, input logic trace);
      @(posedge clk) sysReset <= '{1'b1, run, trace};
      @(posedge clk) sysReset <= '0;
   endtask : sysRst
endmodule : dcf_core_model

// >>> tb/dcf_regs_asserts.sv
// Port-level checker for the comparator and FIFO read-out block.
// Assumes bind to the block; pattern shadows follow completed APB writes.
`timescale 1ns/100ps
module dcf_regs_asserts
   import dcf_pkg::*;
(
   // Clock, reset and APB
   input wire logic clk, rst_b, psel, penable, pwrite, pready, pslverr,
   input wire logic [31:0] paddr, pwdata,
   input wire logic [3:0] pstrb, fifoCount,
   // Core side and matches
   input wire dcf_bus_t coreBus,
   input wire dcf_sysrst_t sysReset,
   input wire logic cmpBMatch, cmpCMatch
);
   logic [31:0] pat_r;
   logic [7:0] ctl_r;
   wire done = psel && penable && pready && !pslverr;
   wire wrEn = done && pwrite && pstrb[0];
   wire keep = sysReset.endTrace && ctl_r[CTRL_DBG_ENABLE] && !ctl_r[CTRL_BEGIN_TRIG];
   wire clr = sysReset.req && !sysReset.endRun && !keep;
   wire noCap = !ctl_r[CTRL_CAPTURE_EN];
   wire popRd = done && !pwrite && paddr == 32'h0000_C05C && noCap;
   wire fifoWr = wrEn && paddr[31:3] == 29'h0000_180B && noCap;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pat_r <= '0;
         ctl_r <= '0;
      end else if (clr) begin
         pat_r <= '0;
         ctl_r <= '0;
      end else if (wrEn) begin
         case (paddr)
            32'h0000_C048: pat_r[31:24] <= pwdata[7:0];
            32'h0000_C04C: pat_r[23:16] <= pwdata[7:0];
            32'h0000_C050: pat_r[15:8] <= pwdata[7:0];
            32'h0000_C054: pat_r[7:0] <= pwdata[7:0];
            32'h0000_C0C0: ctl_r <= pwdata[7:0] & CTRL_WR_MASK;
            default: ;
         endcase
      end
   end
   default clocking dc @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_rst; $rose(rst_b) |-> fifoCount == 4'h0 && !cmpBMatch && !cmpCMatch; endproperty
   a_rst: assert property (p_rst) else $error("state not clear after reset");
   property p_clr; sysReset.req && clr |-> ##2 fifoCount == 4'h0; endproperty
   a_clr: assert property (p_clr) else $error("fifo kept over clearing reset");
   property p_keep; sysReset.req && keep && !sysReset.endRun && noCap |-> ##2 $stable(fifoCount); endproperty
   a_keep: assert property (p_keep) else $error("fifo lost over trace reset");
   property p_cmpB; !ctl_r[CTRL_FULL_MODE] |=> cmpBMatch == $past(coreBus.valid && coreBus.addr == pat_r[31:16]); endproperty
   a_cmpB: assert property (p_cmpB) else $error("comparator B address match wrong");
   property p_full; ctl_r[CTRL_FULL_MODE] |=> cmpBMatch == $past(coreBus.valid && coreBus.data == pat_r[23:16]); endproperty
   a_full: assert property (p_full) else $error("comparator B data match wrong");
   property p_cmpC; 1'b1 |=> cmpCMatch == $past(coreBus.valid && coreBus.addr == pat_r[15:0]); endproperty
   a_cmpC: assert property (p_cmpC) else $error("comparator C match wrong");
   property p_pop; popRd && fifoCount != 4'h0 |-> ##2 fifoCount == $past(fifoCount, 2) - 4'h1; endproperty
   a_pop: assert property (p_pop) else $error("low read did not pop");
   property p_wrFifo; fifoWr |-> ##2 fifoCount == $past(fifoCount, 2); endproperty
   a_wrFifo: assert property (p_wrFifo) else $error("fifo write changed count");
endmodule : dcf_regs_asserts
bind dcf_regs dcf_regs_asserts i_dcf_regs_asserts (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .fifoCount(fifoCount), .coreBus(coreBus), .sysReset(sysReset), .cmpBMatch(cmpBMatch), .cmpCMatch(cmpCMatch));

// >>> tb/dcf_regs_tb.sv
// Self-checking bench for the comparator and trace FIFO read-out block.
// Assumes the core model drives every processor-side input.
`timescale 1ns/100ps
module dcf_regs_tb;
   import dcf_pkg::*;
   localparam logic [31:0] BU = {14'h0, IDX_CMP_B_UPPER, 2'h0}, BL = {14'h0, IDX_CMP_B_LOWER, 2'h0};
   localparam logic [31:0] CU = {14'h0, IDX_CMP_C_UPPER, 2'h0}, CL = {14'h0, IDX_CMP_C_LOWER, 2'h0};
   localparam logic [31:0] FH = {14'h0, IDX_FIFO_HIGH, 2'h0}, FL = {14'h0, IDX_FIFO_LOW, 2'h0};
   localparam logic [31:0] CT = {14'h0, IDX_TRACE_CTRL, 2'h0};
   logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, r;
   logic [3:0] pstrb = 4'hF, fifoCount;
   logic pready, pslverr, cmpBMatch, cmpCMatch, fifoFull;
   dcf_bus_t coreBus;
   dcf_cof_t cofCapture;
   dcf_sysrst_t sysReset;
   int n_fail = 0, num_checks = 0;
   dcf_regs i_dcf_regs (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .coreBus(coreBus), .cofCapture(cofCapture), .sysReset(sysReset), .cmpBMatch(cmpBMatch),
      .cmpCMatch(cmpCMatch), .fifoCount(fifoCount), .fifoFull(fifoFull));
   dcf_core_model i_dcf_core_model (.clk(clk), .coreBus(coreBus), .cofCapture(cofCapture), .sysReset(sysReset));
   always #10 clk = ~clk;
   task automatic chk(input logic [31:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Bounded wait: a slave that never answers counts as a mismatch
   task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] d);
      int k;
      k = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk) penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1 && ++k < 20);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20) n_fail++;
   endtask : apb
   task automatic rd(input logic [31:0] a, exp);
      apb(1'b0, a, 8'h0);
      chk(r, exp);
   endtask : rd
   task automatic cyc(input logic [15:0] a, input logic [7:0] d, input logic b, c);
      i_dcf_core_model.busCycle(a, d);
      @(negedge clk);
      chk({30'h0, cmpBMatch, cmpCMatch}, {30'h0, b, c});
   endtask : cyc
   task automatic s_reset();
      // Indices of the six registers are contiguous from comparator B upper
      for (int i = 0; i < 6; i++) rd(BU + 32'(i) * 32'h4, 32'h0);
      apb(1'b0, 32'h0004_0000, 8'h0);
      chk({31'h0, e}, 32'h1);
   endtask : s_reset
   task automatic s_cmp();
      apb(1'b1, BU, 8'hA5);
      apb(1'b1, BL, 8'h5A);
      apb(1'b1, CU, 8'h3C);
      apb(1'b1, CL, 8'hC3);
      // Strobe lane 0 off: the write must be ignored
      pstrb <= 4'hE;
      apb(1'b1, BU, 8'hFF);
      pstrb <= 4'hF;
      rd(BU, 32'hA5);
      rd(CL, 32'hC3);
      cyc(16'h3CC3, 8'h0, 1'b0, 1'b1);
      cyc(16'hBCC3, 8'h0, 1'b0, 1'b0);
      cyc(16'h3CC2, 8'h0, 1'b0, 1'b0);
      cyc(16'hA55A, 8'h0, 1'b1, 1'b0);
      cyc(16'h255A, 8'h0, 1'b0, 1'b0);
      cyc(16'hA55B, 8'h0, 1'b0, 1'b0);
      apb(1'b1, CT, 8'h01);
      cyc(16'h0000, 8'h5A, 1'b1, 1'b0);
      cyc(16'hA55A, 8'h5B, 1'b0, 1'b0);
      apb(1'b1, CT, 8'h00);
   endtask : s_cmp
   task automatic s_fifo();
      apb(1'b1, CT, 8'h10);
      i_dcf_core_model.cof(16'h1234);
      i_dcf_core_model.cof(16'hABCD);
      apb(1'b1, CT, 8'h00);
      apb(1'b1, FH, 8'hFF);
      apb(1'b1, FL, 8'hFF);
      // Look once the edge of the last write has settled
      @(negedge clk);
      chk({28'h0, fifoCount}, 32'h2);
      rd(FH, 32'h12);
      rd(FL, 32'h34);
      rd(FH, 32'hAB);
      rd(FL, 32'hCD);
      rd(FL, 32'h00);
   endtask : s_fifo
   task automatic s_full();
      apb(1'b1, CT, 8'h10);
      // One capture more than the depth: the last one must be dropped
      for (int i = 0; i <= FIFO_DEPTH; i++) i_dcf_core_model.cof(16'h1000 + 16'(i));
      apb(1'b1, CT, 8'h00);
      @(negedge clk);
      chk({28'h0, fifoCount}, {28'h0, FIFO_CNT_FULL});
      chk({31'h0, fifoFull}, 32'h1);
      for (int i = 0; i < FIFO_DEPTH; i++) rd(FL, 32'(i));
      rd(FL, 32'h00);
      @(negedge clk);
      chk({31'h0, fifoFull}, 32'h0);
   endtask : s_full
   task automatic s_event();
      // Head entry has a nonzero high byte so the event-only masking shows
      apb(1'b1, CT, 8'h10);
      i_dcf_core_model.cof(16'h9ABC);
      apb(1'b1, CT, 8'h12);
      i_dcf_core_model.busCycle(16'hA55A, 8'h77);
      i_dcf_core_model.busCycle(16'hA55A, 8'h88);
      apb(1'b1, CT, 8'h02);
      rd(FH, 32'h00);
      rd(FL, 32'hBC);
      rd(FL, 32'h77);
      rd(FL, 32'h88);
      apb(1'b1, CT, 8'h00);
   endtask : s_event
   task automatic s_sysrst();
      apb(1'b1, CT, 8'h14);
      i_dcf_core_model.cof(16'h5678);
      apb(1'b1, CT, 8'h04);
      i_dcf_core_model.sysRst(1'b0, 1'b1);
      rd(CU, 32'h3C);
      rd(FH, 32'h56);
      // Begin-trigger set: an end-trace reset clears after all
      apb(1'b1, CT, 8'h0C);
      i_dcf_core_model.sysRst(1'b0, 1'b1);
      rd(CU, 32'h00);
      rd(FL, 32'h00);
      apb(1'b1, CU, 8'h3C);
      i_dcf_core_model.sysRst(1'b0, 1'b0);
      rd(CU, 32'h00);
      rd(FL, 32'h00);
   endtask : s_sysrst
   task automatic complete_run();
      if (n_fail == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : complete_run
   initial begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      s_reset();
      s_cmp();
      s_fifo();
      s_full();
      s_event();
      s_sysrst();
      complete_run();
   end
   initial begin
      #200000;
      n_fail++;
      complete_run();
   end
endmodule : dcf_regs_tb
